// ---- dv/eth_dma_event_fifo_ctrl_bench.sv ----
module eth_dma_event_fifo_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        I_SYS_CLK = 1'b0;
	logic        I_RESET = 1'b1;
	logic        I_WR = 1'b0;
	logic        I_RD = 1'b0;
	logic        I_MAC_IRQ = 1'b0;
	logic        I_TX_DESC_VALID = 1'b0;
	logic        I_TX_DESC_HAS_END = 1'b0;
	logic        I_TX_FIFO_WHOLE_FRAME = 1'b0;
	logic        I_RX_DESC_OWNED = 1'b0;
	logic [7:0]  I_ADDR = 8'h00;
	logic [7:0]  I_TX_DESC_STATUS = 8'h00;
	logic [31:0] I_WDATA = 32'h0;
	logic [12:0] I_TX_FIFO_BYTES = 13'h0000;
	logic [13:0] pulse;
	logic [31:0] O_RDATA;
	logic        O_IRQ, O_TX_ACTIVE, O_RX_READY, O_TX_DRAIN, O_SOFT_RESET_BUSY;
	logic        O_TX_ERR_SUMMARY, O_RX_ERR_SUMMARY;
	logic [10:0] O_TX_START_CODE;
	logic [4:0]  O_TX_DEPTH_CODE, O_RX_DEPTH_CODE;
	wire         I_TX_BATCH_END = pulse[0];
	wire         I_TX_DESC_FETCH = pulse[1];
	wire         I_RX_FRAME_DONE = pulse[2];
	wire         I_RX_DESC_FETCH = pulse[3];
	wire         I_RX_DISCARD = pulse[4];
	wire         I_TX_ABORT = pulse[5];
	wire         I_RX_ABORT = pulse[6];
	wire         I_RX_CNT_OVF = pulse[7];
	wire         I_DMA_FAULT = pulse[8];
	wire         I_RX_OVERFLOW = pulse[9];
	wire         I_WRITEBACK = pulse[10];
	wire         I_TX_PORT_EVT = pulse[11];
	wire         I_RX_PORT_EVT = pulse[12];
	wire         I_TX_FIFO_EMPTY = pulse[13];
	wire         I_TX_IN_FRAME = pulse[13];
	wire [7:0]   I_RX_DESC_STATUS = I_TX_DESC_STATUS;
	int          failures = 0;
	int          checks = 0;
	int          pi[11] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 13};
	int          sb[11] = '{21, 20, 18, 17, 26, 25, 24, 23, 16, 30, 19};
	eth_dma_event_fifo_ctrl dut (.*);
	mac_side_model m (.i_clk(I_SYS_CLK), .o_pulse(pulse));
	always #2 I_SYS_CLK = ~I_SYS_CLK;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_SYS_CLK) begin
			I_WR <= 1'b1;
			I_ADDR <= a;
			I_WDATA <= d;
		end
		@(posedge I_SYS_CLK) I_WR <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge I_SYS_CLK) begin
			I_RD <= 1'b1;
			I_ADDR <= a;
		end
		@(posedge I_SYS_CLK) I_RD <= 1'b0;
		#1 chk(O_RDATA, e);
	endtask
	task automatic close_out;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge I_SYS_CLK);
		failures++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge I_SYS_CLK);
		I_RESET <= 1'b0;
		for (int a = 8'h14; a <= 8'h2C; a += 4) rd(8'(a), 32'h0);
		rd(8'h30, 32'h0);
		foreach (pi[i]) begin
			m.fire(pi[i], 1);
			rd(8'h14, 32'h1 << sb[i]);
			chk(32'(O_IRQ), 32'h0);
			wr(8'h18, 32'h1 << sb[i]);
			@(posedge I_SYS_CLK);
			#1 chk(32'(O_IRQ), 32'h1);
			wr(8'h14, ~(32'h1 << sb[i]));
			rd(8'h14, 32'h1 << sb[i]);
			wr(8'h14, 32'h1 << sb[i]);
			rd(8'h14, 32'h0);
			wr(8'h18, 32'h0);
		end
		I_TX_DESC_VALID <= 1'b1;
		I_TX_DESC_HAS_END <= 1'b1;
		m.fire(1, 1);
		I_TX_DESC_VALID <= 1'b0;
		m.fire(1, 1);
		rd(8'h14, 32'h0);
		@(posedge I_SYS_CLK) I_MAC_IRQ <= 1'b1;
		wr(8'h14, 32'h0040_0000);
		rd(8'h14, 32'h0040_0000);
		wr(8'h24, 32'h3FF);
		rd(8'h24, 32'h3FF);
		wr(8'h28, 32'h0F0F);
		rd(8'h28, 32'h0F0F);
		wr(8'h04, 32'h1);
		wr(8'h24, 32'h2);
		wr(8'h28, 32'h0);
		rd(8'h24, 32'h3FF);
		rd(8'h28, 32'h0F00);
		m.fire(0, 1);
		wr(8'h24, 32'h2);
		@(posedge I_SYS_CLK) I_TX_FIFO_BYTES <= 13'h0009;
		repeat (2) @(posedge I_SYS_CLK);
		#1 chk(32'(O_TX_DRAIN), 32'h1);
		@(posedge I_SYS_CLK) I_TX_FIFO_BYTES <= 13'h0008;
		repeat (2) @(posedge I_SYS_CLK);
		#1 chk(32'(O_TX_DRAIN), 32'h0);
		wr(8'h08, 32'h1);
		m.fire(2, 1);
		#1 chk(32'(O_RX_READY), 32'h0);
		wr(8'h2C, 32'h1);
		wr(8'h08, 32'h1);
		m.fire(2, 1);
		#1 chk(32'(O_RX_READY), 32'h1);
		wr(8'h2C, 32'h0);
		wr(8'h28, 32'h0F05);
		rd(8'h2C, 32'h1);
		rd(8'h28, 32'h0F00);
		m.fire(3, 1);
		#1 chk(32'(O_RX_READY), 32'h0);
		wr(8'h1C, 32'h0101);
		I_TX_DESC_STATUS <= 8'h01;
		m.fire(11, 1);
		m.fire(12, 1);
		#1 chk({O_TX_ERR_SUMMARY, O_RX_ERR_SUMMARY}, 32'h0);
		I_TX_DESC_STATUS <= 8'h02;
		m.fire(11, 1);
		m.fire(12, 1);
		#1 chk({O_TX_ERR_SUMMARY, O_RX_ERR_SUMMARY}, 32'h3);
		m.fire(4, 3);
		rd(8'h20, 32'h3);
		wr(8'h20, 32'h1234);
		rd(8'h20, 32'h0);
		m.fire(4, 65540);
		rd(8'h20, 32'hFFFF);
		wr(8'h18, 32'h0400_0000);
		wr(8'h00, 32'h1);
		chk(32'(O_SOFT_RESET_BUSY), 32'h1);
		repeat (70) @(posedge I_SYS_CLK);
		#1 chk(32'(O_SOFT_RESET_BUSY), 32'h0);
		rd(8'h18, 32'h0);
		rd(8'h20, 32'hFFFF);
		close_out();
	end
endmodule

// ---- dv/event_ctrl_monitor.sv ----
module event_ctrl_monitor #(
	parameter int LEVEL_W = 13
) (
	input wire logic               I_SYS_CLK,
	input wire logic               I_RESET,
	input wire logic [7:0]         I_ADDR,
	input wire logic [31:0]        I_WDATA,
	input wire logic               I_WR,
	input wire logic [LEVEL_W-1:0] I_TX_FIFO_BYTES,
	input wire logic               I_TX_FIFO_WHOLE_FRAME,
	input wire logic               I_TX_BATCH_END,
	input wire logic               I_RX_DESC_FETCH,
	input wire logic               I_RX_DESC_OWNED,
	input wire logic               O_TX_ACTIVE,
	input wire logic               O_RX_READY,
	input wire logic               O_TX_DRAIN,
	input wire logic [10:0]        O_TX_START_CODE,
	input wire logic [4:0]         O_TX_DEPTH_CODE,
	input wire logic [4:0]         O_RX_DEPTH_CODE,
	input wire logic               O_SOFT_RESET_BUSY
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	wire sw = I_WR && I_ADDR == 8'h00 && I_WDATA[0];
	property p_drain;
		1 |=> O_TX_DRAIN == $past(I_TX_FIFO_WHOLE_FRAME
			|| (O_TX_START_CODE != 11'h000 && I_TX_FIFO_BYTES > {O_TX_START_CODE, 2'b00}));
	endproperty
	property p_start_lock;
		O_TX_ACTIVE && !sw |=> $stable(O_TX_START_CODE);
	endproperty
	property p_tx_depth_lock;
		O_TX_ACTIVE && !sw |=> $stable(O_TX_DEPTH_CODE);
	endproperty
	property p_rx_depth_lock;
		O_RX_READY && !sw |=> $stable(O_RX_DEPTH_CODE);
	endproperty
	property p_batch;
		I_TX_BATCH_END && !(I_WR && I_ADDR == 8'h04) |=> !O_TX_ACTIVE;
	endproperty
	property p_unowned;
		I_RX_DESC_FETCH && !I_RX_DESC_OWNED && !(I_WR && I_ADDR == 8'h08) |=> !O_RX_READY;
	endproperty
	property p_sw_clear;
		sw |=> !O_TX_ACTIVE && !O_RX_READY && O_TX_START_CODE == 11'h000;
	endproperty
	property p_sw_busy;
		sw |=> O_SOFT_RESET_BUSY ##62 O_SOFT_RESET_BUSY;
	endproperty
	a_drain: assert property (p_drain) else $error("drain level wrong");
	a_start_lock: assert property (p_start_lock) else $error("start code moved");
	a_tx_depth_lock: assert property (p_tx_depth_lock) else $error("tx depth moved");
	a_rx_depth_lock: assert property (p_rx_depth_lock) else $error("rx depth moved");
	a_batch: assert property (p_batch) else $error("tx still active");
	a_unowned: assert property (p_unowned) else $error("rx ready kept");
	a_sw_clear: assert property (p_sw_clear) else $error("soft reset left state");
	a_sw_busy: assert property (p_sw_busy) else $error("busy too short");
	c_drain: cover property (O_TX_DRAIN);
	c_sw: cover property (sw);
	c_unowned: cover property (I_RX_DESC_FETCH && !I_RX_DESC_OWNED && O_RX_READY);
endmodule

bind eth_dma_event_fifo_ctrl event_ctrl_monitor #(.LEVEL_W(LEVEL_W)) mon (.*);

// ---- dv/mac_side_model.sv ----
module mac_side_model (
	input  wire logic        i_clk,
	output logic      [13:0] o_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_pulse = 14'h0000;
	// event line held for k sampling edges
	task automatic fire(input int n, input int k);
		@(posedge i_clk) o_pulse[n] <= 1'b1;
		repeat (k) @(posedge i_clk);
		o_pulse[n] <= 1'b0;
	endtask
endmodule

// ---- hw/eth_dma_event_fifo_ctrl.v ----
// Strobed register access and the address map are this design's own decisions.
`include "eth_dma_event_regs.vh"

// Notes on behaviour
// - status flags clear on writing one, except bit 22
// - bit 22 mirrors MAC core interrupt line
// - batch done once after all frames
// - tx depletion unless after frame end
// - underflow when FIFO empties mid frame
// - frame done per received frame always
// - rx depletion sets flag, clears ready
// - abort, overflow, fault flags write-one-clear
// - enable bit gates each flag
// - tx mask one excludes status bit
// - rx mask one excludes status bit
// - discard counter saturates at all ones
// - any write to the counter clears it
// - start code zero store-and-forward, else 4n
// - drain on whole frame or threshold
// - start level locked while tx active
// - tx depth 256(k+1), locked while active
// - rx depth same, locked while ready
// - select zero clears ready per frame
// - select one runs until stop/unowned
// - rearm select locked while ready
// - soft reset spares discard counter
module eth_dma_event_fifo_ctrl #(
	parameter CNT_W   = 16,
	parameter LEVEL_W = 13
) (
	input  wire        I_SYS_CLK,
	input  wire        I_RESET,
	input  wire [7:0]  I_ADDR,
	input  wire [31:0] I_WDATA,
	input  wire        I_WR,
	input  wire        I_RD,
	output reg  [31:0] O_RDATA,
	input  wire        I_MAC_IRQ,
	input  wire        I_TX_BATCH_END,
	input  wire        I_TX_DESC_FETCH,
	input  wire        I_TX_DESC_VALID,
	input  wire        I_TX_DESC_HAS_END,
	input  wire        I_TX_FIFO_EMPTY,
	input  wire        I_TX_IN_FRAME,
	input  wire [LEVEL_W-1:0] I_TX_FIFO_BYTES,
	input  wire        I_TX_FIFO_WHOLE_FRAME,
	input  wire        I_RX_FRAME_DONE,
	input  wire        I_RX_DESC_FETCH,
	input  wire        I_RX_DESC_OWNED,
	input  wire        I_RX_DISCARD,
	input  wire        I_TX_ABORT,
	input  wire        I_RX_ABORT,
	input  wire        I_RX_CNT_OVF,
	input  wire        I_DMA_FAULT,
	input  wire        I_RX_OVERFLOW,
	input  wire        I_WRITEBACK,
	input  wire [7:0]  I_TX_DESC_STATUS,
	input  wire [7:0]  I_RX_DESC_STATUS,
	input  wire        I_TX_PORT_EVT,
	input  wire        I_RX_PORT_EVT,
	output reg         O_IRQ,
	output reg         O_TX_ACTIVE,
	output reg         O_RX_READY,
	output reg         O_TX_DRAIN,
	output reg         O_TX_ERR_SUMMARY,
	output reg         O_RX_ERR_SUMMARY,
	output reg  [`START_CODE_W-1:0] O_TX_START_CODE,
	output reg  [`DEPTH_CODE_W-1:0] O_TX_DEPTH_CODE,
	output reg  [`DEPTH_CODE_W-1:0] O_RX_DEPTH_CODE,
	output reg         O_SOFT_RESET_BUSY
);

	reg  [31:0]        status_r;
	reg  [31:0]        enable_r;
	reg  [15:0]        err_mask_r;
	reg  [CNT_W-1:0]   discard_count_r;
	reg  [1:0]         rearm_r;
	reg  [6:0]         srst_cnt_r;
	reg                tx_after_end_r;
	reg                mode_r;
	wire               rx_auto_clear_select;
	wire               soft_rst;
	wire               mod_rst;
	wire               wr_status;
	wire [31:0]        set_vec;
	wire [31:0]        clr_vec;
	wire [31:0]        status_nxt;
	wire               tx_desc_empty_evt;
	wire               rx_desc_empty_evt;
	wire [LEVEL_W-1:0] start_bytes;
	wire [31:0]        start_prod;
	reg  [31:0]        rd_nxt;

	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	assign rx_auto_clear_select = rearm_r[0];
	assign soft_rst  = I_WR && hit(I_ADDR, `OFF_MODE) && I_WDATA[0];
	assign mod_rst   = I_RESET || soft_rst;
	assign wr_status = I_WR && hit(I_ADDR, `OFF_EVENT_STATUS);

	// invalid descriptor right after frame end is not depletion
	assign tx_desc_empty_evt = I_TX_DESC_FETCH && !I_TX_DESC_VALID
		&& !tx_after_end_r;
	assign rx_desc_empty_evt = I_RX_DESC_FETCH && !I_RX_DESC_OWNED;

	assign set_vec = {1'b0, I_WRITEBACK, 3'b000,
		I_TX_ABORT, I_RX_ABORT, I_RX_CNT_OVF, I_DMA_FAULT,
		1'b0,
		I_TX_BATCH_END,
		tx_desc_empty_evt,
		I_TX_FIFO_EMPTY && I_TX_IN_FRAME,
		I_RX_FRAME_DONE,
		rx_desc_empty_evt,
		I_RX_OVERFLOW,
		I_TX_PORT_EVT ? (I_TX_DESC_STATUS & ~err_mask_r[15:8]) : 8'h00,
		I_RX_PORT_EVT ? (I_RX_DESC_STATUS & ~err_mask_r[7:0]) : 8'h00};

	// write one clears; a simultaneous set wins
	assign clr_vec = wr_status ? (I_WDATA & `STATUS_W1C_MASK) : 32'h00000000;
	assign status_nxt = ((status_r & ~clr_vec) | set_vec) & `STATUS_W1C_MASK;

	// code n means 4n bytes; code zero waits for a whole frame
	assign start_prod  = {21'h000000, O_TX_START_CODE} * `BYTES_PER_CODE;
	assign start_bytes = start_prod[LEVEL_W-1:0];

	always @(posedge I_SYS_CLK) begin
		if (mod_rst) begin
			status_r         <= 32'h00000000;
			enable_r         <= 32'h00000000;
			err_mask_r       <= 16'h0000;
			rearm_r          <= 2'b00;
			tx_after_end_r   <= 1'b0;
			mode_r           <= 1'b0;
			O_TX_ACTIVE      <= 1'b0;
			O_RX_READY       <= 1'b0;
			O_TX_START_CODE  <= 11'h000;
			O_TX_DEPTH_CODE  <= 5'h00;
			O_RX_DEPTH_CODE  <= 5'h00;
			O_IRQ            <= 1'b0;
			O_TX_DRAIN       <= 1'b0;
			O_TX_ERR_SUMMARY <= 1'b0;
			O_RX_ERR_SUMMARY <= 1'b0;
		end else begin
			status_r <= status_nxt | ({31'h0, I_MAC_IRQ} << `BIT_MAC_IRQ);
			O_IRQ <= |(((status_nxt & `STATUS_W1C_MASK) |
				({31'h0, I_MAC_IRQ} << `BIT_MAC_IRQ)) & enable_r);
			if (I_TX_DESC_FETCH)
				tx_after_end_r <= I_TX_DESC_VALID && I_TX_DESC_HAS_END;
			if (I_WR && hit(I_ADDR, `OFF_MODE))
				mode_r <= I_WDATA[6];
			if (I_WR && hit(I_ADDR, `OFF_EVENT_ENABLE))
				enable_r <= I_WDATA & `ENABLE_RW_MASK;
			if (I_WR && hit(I_ADDR, `OFF_DESC_ERR_MASK))
				err_mask_r <= I_WDATA[15:0];
			// locked while transmit is active
			if (I_WR && hit(I_ADDR, `OFF_TX_START_LEVEL) && !O_TX_ACTIVE)
				O_TX_START_CODE <= I_WDATA[`START_CODE_W-1:0];
			if (I_WR && hit(I_ADDR, `OFF_QUEUE_DEPTH)) begin
				if (!O_TX_ACTIVE)
					O_TX_DEPTH_CODE <= I_WDATA[12:8];
				if (!O_RX_READY)
					O_RX_DEPTH_CODE <= I_WDATA[4:0];
			end
			if (I_WR && hit(I_ADDR, `OFF_RX_REARM) && !O_RX_READY)
				rearm_r <= I_WDATA[1:0];
			// tx go: write one starts, hardware clears at end or depletion
			if (I_WR && hit(I_ADDR, `OFF_TX_GO) && I_WDATA[0])
				O_TX_ACTIVE <= 1'b1;
			else if (I_TX_BATCH_END || tx_desc_empty_evt)
				O_TX_ACTIVE <= 1'b0;
			// rx ready clear sources; software write one takes priority
			if (I_WR && hit(I_ADDR, `OFF_RX_READY))
				O_RX_READY <= I_WDATA[0];
			else if (rx_desc_empty_evt)
				O_RX_READY <= 1'b0;
			else if (I_RX_FRAME_DONE && !rx_auto_clear_select)
				O_RX_READY <= 1'b0;
			O_TX_DRAIN <= I_TX_FIFO_WHOLE_FRAME ||
				((O_TX_START_CODE != 11'h000) && (I_TX_FIFO_BYTES > start_bytes));
			if (I_TX_PORT_EVT)
				O_TX_ERR_SUMMARY <= |(I_TX_DESC_STATUS & ~err_mask_r[15:8]);
			if (I_RX_PORT_EVT)
				O_RX_ERR_SUMMARY <= |(I_RX_DESC_STATUS & ~err_mask_r[7:0]);
		end
	end

	// counter kept across soft reset
	always @(posedge I_SYS_CLK) begin
		if (I_RESET)
			discard_count_r <= {CNT_W{1'b0}};
		else if (I_WR && hit(I_ADDR, `OFF_DISCARD_COUNTER))
			discard_count_r <= {CNT_W{1'b0}};
		else if (I_RX_DISCARD && (discard_count_r != {CNT_W{1'b1}}))
			discard_count_r <= discard_count_r + {{(CNT_W-1){1'b0}}, 1'b1};
	end

	// busy window after soft reset
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			srst_cnt_r        <= 7'd0;
			O_SOFT_RESET_BUSY <= 1'b0;
		end else if (soft_rst) begin
			srst_cnt_r        <= `SOFT_RESET_CYCLES;
			O_SOFT_RESET_BUSY <= 1'b1;
		end else if (srst_cnt_r != 7'd0) begin
			srst_cnt_r        <= srst_cnt_r - 7'd1;
			O_SOFT_RESET_BUSY <= (srst_cnt_r != 7'd1);
		end
	end

	always @* begin
		rd_nxt = 32'h00000000;
		case (I_ADDR)
		`OFF_MODE:            rd_nxt = {25'h0, mode_r, 6'h00};
		`OFF_TX_GO:           rd_nxt = {31'h0, O_TX_ACTIVE};
		`OFF_RX_READY:        rd_nxt = {31'h0, O_RX_READY};
		`OFF_EVENT_STATUS:    rd_nxt = status_r;
		`OFF_EVENT_ENABLE:    rd_nxt = enable_r;
		`OFF_DESC_ERR_MASK:   rd_nxt = {16'h0, err_mask_r};
		`OFF_DISCARD_COUNTER: rd_nxt = {{(32-CNT_W){1'b0}}, discard_count_r};
		`OFF_TX_START_LEVEL:  rd_nxt = {21'h0, O_TX_START_CODE};
		`OFF_QUEUE_DEPTH:     rd_nxt = {19'h0, O_TX_DEPTH_CODE, 3'b000, O_RX_DEPTH_CODE};
		`OFF_RX_REARM:        rd_nxt = {30'h0, rearm_r};
		default:              rd_nxt = 32'h00000000;
		endcase
	end

	always @(posedge I_SYS_CLK) begin
		if (I_RESET)
			O_RDATA <= 32'h00000000;
		else if (I_RD)
			O_RDATA <= rd_nxt;
		else
			O_RDATA <= 32'h00000000;
	end

endmodule

// ---- hw/eth_dma_event_regs.vh ----
`ifndef ETH_DMA_EVENT_REGS_VH
`define ETH_DMA_EVENT_REGS_VH

// word offsets (byte addresses)
`define OFF_MODE            8'h00
`define OFF_TX_GO           8'h04
`define OFF_RX_READY        8'h08
`define OFF_EVENT_STATUS    8'h14
`define OFF_EVENT_ENABLE    8'h18
`define OFF_DESC_ERR_MASK   8'h1C
`define OFF_DISCARD_COUNTER 8'h20
`define OFF_TX_START_LEVEL  8'h24
`define OFF_QUEUE_DEPTH     8'h28
`define OFF_RX_REARM        8'h2C

// event status bit positions
`define BIT_WRITEBACK   30
`define BIT_TX_ABORT    26
`define BIT_RX_ABORT    25
`define BIT_RX_CNT_OVF  24
`define BIT_DMA_FAULT   23
`define BIT_MAC_IRQ     22
`define BIT_TX_BATCH    21
`define BIT_TX_DESC_EMP 20
`define BIT_TX_UNDER    19
`define BIT_RX_DONE     18
`define BIT_RX_DESC_EMP 17
`define BIT_RX_OVF      16

// writable masks
`define STATUS_W1C_MASK 32'h47BFFFFF
`define ENABLE_RW_MASK  32'h7FFFFFFF
`define ERR_MASK_RW     32'h0000FFFF

// field layout
`define START_CODE_W    11
`define START_CODE_LIM  11'h400
`define DEPTH_CODE_W    5
`define DEPTH_CODE_LIM  5'h10
`define TX_DEPTH_LSB    8
`define CNT_MAX         16'hFFFF
`define BYTES_PER_CODE  4
`define BYTES_PER_DEPTH 256

// software reset hold
`define SOFT_RESET_CYCLES 7'd64

`endif
